// >>> serial_port_core.sv
// register-side core of the serial port: APB registers, send path, receive path
// assumes rxd_i and rx_clk_i come from pins and are asynchronous to clk_sys_i
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module serial_port_core
	import serial_port_pkg::*;
#(
	parameter int unsigned BAUD_CYCLES = BAUD_BASE_CYCLES
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// apb slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic pready_o,
	output logic [31:0] prdata_o,
	output logic pslverr_o,
	// serial line
	input wire logic rxd_i,
	input wire logic rx_clk_i,
	output logic rx_clk_o,
	output logic rx_clk_oe_o,
	output logic txd_o,
	// receive interrupt request
	output logic rx_irq_o
);

	// ****************************************
	// pin synchronisers
	// ****************************************
	logic rxd_meta, rxd_sync, rxd_prev;
	logic rxclk_meta, rxclk_sync, rxclk_prev;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rxd_meta <= 1'b1;
			rxd_sync <= 1'b1;
			rxd_prev <= 1'b1;
			rxclk_meta <= 1'b1;
			rxclk_sync <= 1'b1;
			rxclk_prev <= 1'b1;
		end else begin
			rxd_meta <= rxd_i;
			rxd_sync <= rxd_meta;
			rxd_prev <= rxd_sync;
			rxclk_meta <= rx_clk_i;
			rxclk_sync <= rxclk_meta;
			rxclk_prev <= rxclk_sync;
		end
	end

	// ****************************************
	// apb decode
	// ****************************************
	rx_mode_t rx_mode;
	rx_format_t rx_fmt;
	status_t status;
	logic [3:0] baud_sel;
	logic [7:0] tx_buf;
	logic [7:0] rx_buf;
	logic [2:0] status_seen;
	logic [3:0] read_value;
	logic mapped;
	logic [9:0] idx;
	logic setup, access, wr, rd;

	assign idx = paddr_i[ADDR_W-1:2];
	assign setup = psel_i & ~penable_i;
	assign access = psel_i & penable_i & pready_o;
	assign wr = access & pwrite_i & mapped;
	assign rd = access & ~pwrite_i & mapped;

	always_comb begin
		mapped = 1'b1;
		read_value = RST_NIBBLE;
		case (idx)
			IDX_TX_BUFFER_LOW: read_value = tx_buf[3:0];
			IDX_TX_BUFFER_HIGH: read_value = tx_buf[7:4];
			IDX_RX_BUFFER_LOW: read_value = rx_buf[3:0]; // see RL16
			IDX_RX_BUFFER_HIGH: read_value = rx_buf[7:4];
			IDX_RX_MODE_CONTROL: read_value = rx_mode;
			IDX_RX_FORMAT_CONTROL: read_value = rx_fmt;
			IDX_RX_BAUD_SELECT: read_value = baud_sel;
			IDX_SERIAL_ERROR_STATUS: read_value = status;
			default: mapped = 1'b0;
		endcase
	end

	// no wait state: every bus output comes from a flop loaded in the setup cycle
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pready_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
			pslverr_o <= 1'b0;
			status_seen <= 3'h0;
		end else begin
			pready_o <= setup;
			pslverr_o <= setup & ~mapped;
			if (setup) begin
				prdata_o <= {28'h000_0000, read_value};
				// only flags that software actually saw may be cleared
				status_seen <= (~pwrite_i && idx == IDX_SERIAL_ERROR_STATUS) ?
					status[2:0] : 3'h0;
			end
		end
	end

	// ****************************************
	// control registers
	// ****************************************
	logic done_evt, abort_evt;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_mode <= RST_NIBBLE; // see RL7
			rx_fmt <= RST_NIBBLE;
			baud_sel <= RST_BAUD_SELECT; // see RL18
		end else begin
			if (wr && idx == IDX_RX_MODE_CONTROL) begin
				rx_mode <= pwdata_i[3:0]; // see RL9
			end else if (done_evt && rx_mode.rx_mode_select == MODE_SYNC) begin
				rx_mode.rx_enable_bit <= 1'b0; // see RL8
			end
			if (wr && idx == IDX_RX_FORMAT_CONTROL) begin
				rx_fmt <= pwdata_i[3:0];
			end
			if (wr && idx == IDX_RX_BAUD_SELECT) begin
				baud_sel <= pwdata_i[3:0];
			end
		end
	end

	// ****************************************
	// send path
	// ****************************************
	logic tx_busy;
	logic [8:0] tx_shift;
	logic [3:0] tx_cnt;
	logic [CNT_W-1:0] tx_timer;
	logic tx_load, tx_high_wr;

	assign tx_high_wr = wr && idx == IDX_TX_BUFFER_HIGH;
	assign tx_load = status.tx_pending_flag & ~tx_busy; // see RL2

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_buf <= RST_BYTE;
		end else begin
			// a pending byte is simply overwritten
			if (wr && idx == IDX_TX_BUFFER_LOW) begin
				tx_buf[3:0] <= pwdata_i[3:0]; // see RL5
			end
			if (tx_high_wr) begin
				tx_buf[7:4] <= pwdata_i[3:0]; // see RL5
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_busy <= 1'b0;
			tx_shift <= 9'h000; // see RL1
			tx_cnt <= 4'h0;
			tx_timer <= '0;
			txd_o <= 1'b1;
		end else if (tx_load) begin
			tx_busy <= 1'b1;
			tx_shift <= {1'b1, tx_buf};
			tx_cnt <= TX_BITS;
			tx_timer <= CNT_W'(BAUD_CYCLES - 1);
			txd_o <= 1'b0;
		end else if (tx_busy) begin
			if (tx_timer != '0) begin
				tx_timer <= tx_timer - 1'b1;
			end else if (tx_cnt == 4'h0) begin
				tx_busy <= 1'b0; // see RL4
			end else begin
				txd_o <= tx_shift[0];
				tx_shift <= {1'b0, tx_shift[8:1]};
				tx_cnt <= tx_cnt - 1'b1;
				tx_timer <= CNT_W'(BAUD_CYCLES - 1);
			end
		end
	end

	// ****************************************
	// internal shift clock
	// ****************************************
	logic int_run;
	logic [CNT_W-1:0] int_div;
	logic int_rise, ext_rise, shift_edge;

	assign int_run = rx_mode.rx_mode_select & rx_fmt.rx_clock_source & rx_mode.rx_enable_bit;
	assign int_rise = int_run & (int_div == '0) & ~rx_clk_o;
	assign ext_rise = rxclk_sync & ~rxclk_prev;
	assign shift_edge = rx_fmt.rx_clock_source ? int_rise : ext_rise; // see RL13

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			int_div <= '0;
			rx_clk_o <= 1'b1;
			rx_clk_oe_o <= 1'b0;
		end else begin
			rx_clk_oe_o <= rx_mode.rx_mode_select & rx_fmt.rx_clock_source;
			if (!int_run) begin
				int_div <= CNT_W'(INT_HALF_CYCLES - 1);
				rx_clk_o <= 1'b1;
			end else if (int_div == '0) begin
				int_div <= CNT_W'(INT_HALF_CYCLES - 1);
				rx_clk_o <= ~rx_clk_o;
			end else begin
				int_div <= int_div - 1'b1;
			end
		end
	end

	// ****************************************
	// receive sequencer
	// ****************************************
	rx_state_t rx_state;
	logic [7:0] rx_shift;
	logic [2:0] rx_cnt, rx_last, rx_pos;
	logic rx_par, stop_fault;
	logic [CNT_W-1:0] rx_timer, bit_cycles;
	logic is_uart, tick, last_bit;

	assign is_uart = rx_mode.rx_mode_select == MODE_UART; // see RL22
	assign bit_cycles = CNT_W'(BAUD_CYCLES) << baud_sel[1:0]; // see RL18
	assign tick = is_uart ? (rx_timer == '0) : shift_edge;
	assign rx_last = RX_LAST_BASE + {1'b0, rx_mode.rx_length_hi, rx_mode.rx_length_lo};
	assign rx_pos = rx_fmt.rx_bit_order ? rx_last - rx_cnt : rx_cnt; // see RL10
	assign last_bit = rx_cnt == rx_last;

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_state <= RX_IDLE;
			rx_shift <= RST_BYTE; // see RL14
			rx_cnt <= 3'h0;
			rx_par <= 1'b0;
			rx_timer <= '0;
			done_evt <= 1'b0;
			abort_evt <= 1'b0;
			stop_fault <= 1'b0;
		end else begin
			done_evt <= 1'b0;
			abort_evt <= 1'b0;
			if (rx_state != RX_IDLE && is_uart && rx_timer != '0) begin
				rx_timer <= rx_timer - 1'b1;
			end
			case (rx_state)
				RX_IDLE: begin
					rx_cnt <= 3'h0;
					stop_fault <= 1'b0;
					if (rx_mode.rx_enable_bit) begin
						if (is_uart && rxd_prev && !rxd_sync) begin
							rx_shift <= RST_BYTE;
							rx_timer <= bit_cycles >> 1;
							rx_state <= RX_START;
						end else if (!is_uart) begin
							rx_shift <= RST_BYTE;
							rx_state <= RX_DATA;
						end
					end
				end
				RX_START: begin
					if (rx_timer == '0) begin
						if (rxd_sync) begin
							abort_evt <= 1'b1; // see RL21
							done_evt <= 1'b1;
							rx_state <= RX_IDLE;
						end else begin
							// reload one short: the zero cycle itself counts in the bit time
							rx_timer <= bit_cycles - 1'b1;
							rx_state <= RX_DATA;
						end
					end
				end
				RX_DATA: begin
					if (tick) begin
						rx_shift[rx_pos] <= rxd_sync;
						rx_cnt <= rx_cnt + 1'b1;
						rx_timer <= bit_cycles - 1'b1;
						if (last_bit) begin
							if (rx_fmt.rx_parity_on) begin
								rx_state <= RX_PARITY; // see RL12
							end else if (is_uart) begin
								rx_state <= RX_STOP;
							end else begin
								done_evt <= 1'b1;
								rx_state <= RX_IDLE;
							end
						end
					end
				end
				RX_PARITY: begin
					if (tick) begin
						rx_par <= rxd_sync;
						rx_timer <= bit_cycles - 1'b1;
						if (is_uart) begin
							rx_state <= RX_STOP;
						end else begin
							done_evt <= 1'b1;
							rx_state <= RX_IDLE;
						end
					end
				end
				RX_STOP: begin
					if (tick) begin
						stop_fault <= ~rxd_sync; // see RL21
						done_evt <= 1'b1;
						rx_state <= RX_IDLE;
					end
				end
				default: rx_state <= RX_IDLE;
			endcase
		end
	end

	// ****************************************
	// receive buffer, status and interrupt
	// ****************************************
	logic rx_unread, load_evt, parity_fault_flag_now, framing_fault_flag_now, overrun_flag_now;

	assign load_evt = done_evt & ~abort_evt;
	// odd sense wants an odd count of ones over data and parity
	assign parity_fault_flag_now = load_evt & rx_fmt.rx_parity_on &
		((^rx_shift ^ rx_par) == rx_fmt.rx_parity_sense); // see RL11
	assign framing_fault_flag_now = done_evt & is_uart & (abort_evt | stop_fault);
	assign overrun_flag_now = load_evt & rx_unread; // see RL17

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_buf <= RST_BYTE;
			rx_unread <= 1'b0;
		end else begin
			if (load_evt && !rx_unread) begin
				rx_buf <= rx_shift; // see RL15
			end
			// taking the high nibble counts as the byte being taken
			if (load_evt) begin
				rx_unread <= 1'b1;
			end else if (rd && idx == IDX_RX_BUFFER_HIGH) begin
				rx_unread <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			status <= RST_NIBBLE; // see RL19
		end else begin
			if (tx_high_wr) begin
				status.tx_pending_flag <= 1'b1; // see RL2
			end else if (tx_load) begin
				status.tx_pending_flag <= 1'b0; // see RL3
			end
			// a new fault outranks the clear by a status read
			if (parity_fault_flag_now) begin
				status.parity_fault_flag <= 1'b1; // see RL20
			end else if (rd && status_seen[BIT_PARITY_FAULT]) begin
				status.parity_fault_flag <= 1'b0; // see RL24
			end
			if (overrun_flag_now) begin
				status.overrun_flag <= 1'b1;
			end else if (rd && status_seen[BIT_OVERRUN]) begin
				status.overrun_flag <= 1'b0; // see RL24
			end
			if (framing_fault_flag_now) begin
				status.framing_fault_flag <= 1'b1;
			end else if (rd && status_seen[BIT_FRAMING_FAULT]) begin
				status.framing_fault_flag <= 1'b0; // see RL24
			end
		end
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rx_irq_o <= 1'b0;
		end else begin
			rx_irq_o <= done_evt; // see RL15
		end
	end

endmodule

`default_nettype wire

// >>> serial_port_pkg.sv
// constants, field layouts and carrier types of the serial port register core
// assumes a 125 MHz system clock and APB word access, one register per word
// How it works
// RL1 - send register resets zero, CPU cannot reach
// RL2 - high send write sets full, starts idle sender
// RL3 - full flag clears once data enters shifter
// RL4 - busy sender keeps data pending, sends afterwards
// RL5 - write while full replaces pending send data
// RL6 - software checks full flag before writing data
// RL7 - both receive control registers reset to zero
// RL8 - synchronous frame clears enable; UART leaves it
// RL9 - control zero holds length and mode fields
// RL10 - format bit three picks receive bit order
// RL11 - format bit two picks odd/even parity
// RL12 - format bit one says parity bit present
// RL13 - format bit zero picks sync clock source
// RL14 - receive shifter resets zero, CPU cannot reach
// RL15 - frame end loads buffer and raises interrupt; code keeps the old byte in the buffer while it is still unread
// RL16 - receive buffer read-only nibbles, held until next
// RL17 - unread buffer on frame end flags overrun
// RL18 - baud select resets twelve, low bits pick
// RL19 - status read-only, zero at reset, read clears
// RL20 - parity mismatch sets parity fault flag
// RL21 - UART bad start/stop sets framing fault, interrupt
// RL22 - mode zero is UART, one synchronous
// RL23 - software writes low nibble before high nibble
// RL24 - flag set beats clear by status read
package serial_port_pkg;

	// ****************************************
	// clocking and bit timing
	// ****************************************
	localparam int unsigned SYS_CLK_HZ = 125_000_000;
	localparam int unsigned BAUD_BASE_BPS = 9600;
	localparam int unsigned BAUD_BASE_CYCLES = SYS_CLK_HZ / BAUD_BASE_BPS;
	localparam int unsigned INT_CLK_HZ = 32768;
	localparam int unsigned INT_HALF_CYCLES = SYS_CLK_HZ / (2 * INT_CLK_HZ);
	localparam int CNT_W = 17;

	// ****************************************
	// register map (index; byte address is four times)
	// ****************************************
	localparam int ADDR_W = 12;
	localparam logic [9:0] IDX_TX_BUFFER_LOW = 10'h0A4;
	localparam logic [9:0] IDX_TX_BUFFER_HIGH = 10'h0A5;
	localparam logic [9:0] IDX_RX_BUFFER_LOW = 10'h0A8;
	localparam logic [9:0] IDX_RX_BUFFER_HIGH = 10'h0A9;
	localparam logic [9:0] IDX_RX_MODE_CONTROL = 10'h0AA;
	localparam logic [9:0] IDX_RX_FORMAT_CONTROL = 10'h0AB;
	localparam logic [9:0] IDX_RX_BAUD_SELECT = 10'h0AC;
	localparam logic [9:0] IDX_SERIAL_ERROR_STATUS = 10'h0AD;

	// ****************************************
	// reset values and field positions
	// ****************************************
	localparam logic [3:0] RST_NIBBLE = 4'h0;
	localparam logic [3:0] RST_BAUD_SELECT = 4'hC;
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam int BIT_RX_ENABLE = 3;
	localparam int BIT_RX_LENGTH_HI = 2;
	localparam int BIT_RX_LENGTH_LO = 1;
	localparam int BIT_RX_MODE = 0;
	localparam int BIT_TX_PENDING = 3;
	localparam int BIT_PARITY_FAULT = 2;
	localparam int BIT_OVERRUN = 1;
	localparam int BIT_FRAMING_FAULT = 0;
	localparam logic [2:0] RX_LAST_BASE = 3'h4;
	localparam logic [3:0] TX_BITS = 4'h9;
	localparam logic MODE_UART = 1'b0;
	localparam logic MODE_SYNC = 1'b1;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		logic rx_enable_bit;
		logic rx_length_hi;
		logic rx_length_lo;
		logic rx_mode_select;
	} rx_mode_t;

	typedef struct packed {
		logic rx_bit_order;
		logic rx_parity_sense;
		logic rx_parity_on;
		logic rx_clock_source;
	} rx_format_t;

	typedef struct packed {
		logic tx_pending_flag;
		logic parity_fault_flag;
		logic overrun_flag;
		logic framing_fault_flag;
	} status_t;

	typedef enum logic [2:0] {
		RX_IDLE = 3'b000,
		RX_START = 3'b001,
		RX_DATA = 3'b010,
		RX_PARITY = 3'b011,
		RX_STOP = 3'b100
	} rx_state_t;

endpackage

// >>> serial_port_core_properties.sv
// checker of the serial port core: bus answers, control pins, send and receive events
// assumes binding onto serial_port_core; sees its ports only
`timescale 1ns/1ps
`default_nettype none
module serial_port_core_properties
	import serial_port_pkg::*;
#(
	parameter int unsigned BAUD_CYCLES = BAUD_BASE_CYCLES
) (
	// clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// apb
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [ADDR_W-1:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic pready_o,
	input wire logic [31:0] prdata_o,
	input wire logic pslverr_o,
	// line
	input wire logic rxd_i,
	input wire logic rx_clk_i,
	input wire logic rx_clk_o,
	input wire logic rx_clk_oe_o,
	input wire logic txd_o,
	input wire logic rx_irq_o
);
	// **********
	// shadow state
	// **********
	// a queued byte may wait a whole frame behind the one on the line
	localparam int TX_WAIT = 10 * BAUD_CYCLES + 4;
	logic [9:0] idx;
	logic wr;
	logic mapped;
	logic sel;
	logic [3:0] fmt;
	logic msel;
	logic baud_wr;
	logic tx_seen;
	logic rx_seen;
	assign idx = paddr_i[11:2];
	assign wr = psel_i && penable_i && pready_o && pwrite_i;
	assign mapped = idx inside {IDX_TX_BUFFER_LOW, IDX_TX_BUFFER_HIGH, IDX_RX_BUFFER_LOW,
		IDX_RX_BUFFER_HIGH, IDX_RX_MODE_CONTROL, IDX_RX_FORMAT_CONTROL, IDX_RX_BAUD_SELECT,
		IDX_SERIAL_ERROR_STATUS};
	assign sel = msel && fmt[0];
	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fmt <= RST_NIBBLE;
			msel <= 1'b0;
			baud_wr <= 1'b0;
			tx_seen <= 1'b0;
			rx_seen <= 1'b0;
		end else begin
			if (wr && idx == IDX_RX_FORMAT_CONTROL)
				fmt <= pwdata_i[3:0];
			if (wr && idx == IDX_RX_MODE_CONTROL)
				msel <= pwdata_i[0];
			if (wr && idx == IDX_RX_BAUD_SELECT)
				baud_wr <= 1'b1;
			if (wr && idx == IDX_TX_BUFFER_HIGH)
				tx_seen <= 1'b1;
			if (rx_irq_o)
				rx_seen <= 1'b1;
		end
	end
	// **********
	// properties
	// **********
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	sequence s_setup;
		psel_i && !penable_i;
	endsequence
	sequence s_read(i);
		psel_i && !penable_i && !pwrite_i && idx == i;
	endsequence
	property p_apb_err;
		s_setup |=> pready_o && pslverr_o == !mapped;
	endproperty
	a_apb_err: assert property (p_apb_err)
		else $error("bus answer or error flag wrong");
	property p_baud_rst;
		s_read(IDX_RX_BAUD_SELECT) ##0 !baud_wr |=> prdata_o == {28'h0, RST_BAUD_SELECT};
	endproperty
	a_baud_rst: assert property (p_baud_rst)
		else $error("baud select reset value wrong");
	property p_fmt_rb;
		s_read(IDX_RX_FORMAT_CONTROL) |=> prdata_o == {28'h0, fmt};
	endproperty
	a_fmt_rb: assert property (p_fmt_rb)
		else $error("format control read back wrong");
	property p_rxbuf_rst;
		(s_read(IDX_RX_BUFFER_LOW) or s_read(IDX_RX_BUFFER_HIGH)) ##0 !rx_seen
			|=> prdata_o == 32'h0;
	endproperty
	a_rxbuf_rst: assert property (p_rxbuf_rst)
		else $error("receive buffer not zero before any frame");
	property p_clk_oe;
		sel == $past(sel) && sel == $past(sel, 2) |-> rx_clk_oe_o == sel;
	endproperty
	a_clk_oe: assert property (p_clk_oe)
		else $error("receive clock drive enable wrong");
	property p_tx_quiet;
		!tx_seen |-> txd_o;
	endproperty
	a_tx_quiet: assert property (p_tx_quiet)
		else $error("send line active without data");
	property p_tx_start;
		wr && idx == IDX_TX_BUFFER_HIGH |-> ##[1:TX_WAIT] !txd_o;
	endproperty
	a_tx_start: assert property (p_tx_start)
		else $error("send did not start");
	property p_irq_pulse;
		$rose(rx_irq_o) |=> !rx_irq_o;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse)
		else $error("receive request longer than one cycle");
endmodule
`default_nettype wire

// >>> serial_line_model.sv
// remote serial device: drives the receive data and the shift clock pins
// assumes a high mark level on the data line; bit time given in ns
`timescale 1ns/1ps
`default_nettype none
module serial_line_model #(
	parameter int BIT_NS = 128
) (
	// line outputs
	output var logic rxd_o,
	output var logic rx_clk_o
);
	// **********
	// frames
	// **********
	initial begin
		rxd_o = 1'b1;
		rx_clk_o = 1'b1;
	end
	task automatic uart(input logic [7:0] d, input logic pon, input logic pb, input logic sb);
		rxd_o = 1'b0;
		#(BIT_NS);
		for (int i = 0; i < 8; i++) begin
			rxd_o = d[i];
			#(BIT_NS);
		end
		if (pon) begin
			rxd_o = pb;
			#(BIT_NS);
		end
		rxd_o = sb;
		#(BIT_NS);
		rxd_o = 1'b1;
		#(BIT_NS);
	endtask
	// clock stands high between frames; released data flips
	task automatic sync(input logic [7:0] d);
		for (int i = 0; i < 8; i++) begin
			rx_clk_o = 1'b0;
			rxd_o = d[i];
			#32;
			rx_clk_o = 1'b1;
			#32;
		end
		rxd_o = ~rxd_o;
	endtask
endmodule
`default_nettype wire

// >>> test_serial_port_buffer_status.sv
// self-checking bench of the serial port core over apb and the serial line
// assumes the line model and the checker are compiled before it
`timescale 1ns/1ps
`default_nettype none
module test_serial_port_buffer_status
	import serial_port_pkg::*;
;
	// **********
	// bench
	// **********
	localparam int BAUD = 16;
	localparam logic [11:0] A_TXL = 12'h290;
	localparam logic [11:0] A_TXH = 12'h294;
	localparam logic [11:0] A_RXL = 12'h2A0;
	localparam logic [11:0] A_RXH = 12'h2A4;
	localparam logic [11:0] A_MODE = 12'h2A8;
	localparam logic [11:0] A_FMT = 12'h2AC;
	localparam logic [11:0] A_BAUD = 12'h2B0;
	localparam logic [11:0] A_STAT = 12'h2B4;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	wire logic pready, pslverr, txd, rx_irq, clk_dev, clk_oe, rxd, clk_ext, clk_pin;
	wire logic [31:0] prdata;
	logic [31:0] rdat, v;
	logic err;
	logic [7:0] a, b, c, r0, r1;
	int failures = 0;
	int total_checks = 0;
	assign clk_pin = clk_oe ? clk_dev : clk_ext;
	serial_port_core #(.BAUD_CYCLES(BAUD)) i_serial_port_core (
		.clk_sys_i(clk_sys), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
		.pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pready_o(pready),
		.prdata_o(prdata), .pslverr_o(pslverr), .rxd_i(rxd), .rx_clk_i(clk_pin),
		.rx_clk_o(clk_dev), .rx_clk_oe_o(clk_oe), .txd_o(txd), .rx_irq_o(rx_irq));
	serial_line_model #(.BIT_NS(BAUD * 8)) i_serial_line_model (.rxd_o(rxd), .rx_clk_o(clk_ext));
	function automatic logic [7:0] rev8(input logic [7:0] d);
		for (int i = 0; i < 8; i++)
			rev8[i] = d[7 - i];
	endfunction
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d);
		// start on a rising edge; also keeps one edge between two transfers
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do @(posedge clk_sys); while (pready !== 1'b1);
		rdat = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [11:0] ad, input logic [3:0] n);
		apb(1'b1, ad, {28'h0, n});
	endtask
	task automatic rd(input logic [11:0] ad, input logic [3:0] e);
		apb(1'b0, ad, 32'h0);
		chk(rdat, {28'h0, e});
	endtask
	task automatic wait_irq;
		for (int i = 0; i < 600; i++) begin
			@(negedge clk_sys);
			if (rx_irq === 1'b1)
				return;
		end
		chk(32'h0, 32'h1);
	endtask
	task automatic frame(input logic [3:0] f, input logic pbad, input logic sb,
		input logic [3:0] es);
		logic [7:0] d;
		logic [7:0] x;
		d = $urandom;
		x = f[3] ? rev8(d) : d;
		wr(A_FMT, f);
		fork
			i_serial_line_model.uart(d, f[1], (f[2] ? ^d : ~^d) ^ pbad, sb);
			wait_irq;
		join
		rd(A_STAT, es);
		rd(A_RXL, x[3:0]);
		rd(A_RXH, x[7:4]);
	endtask
	task automatic get_tx(output logic [7:0] q);
		@(negedge txd);
		repeat (BAUD / 2) @(negedge clk_sys);
		for (int i = 0; i < 8; i++) begin
			repeat (BAUD) @(negedge clk_sys);
			q[i] = txd;
		end
	endtask
	task automatic close_out;
		$display("checks %0d failures %0d", total_checks, failures);
		if (failures == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	initial forever #4 clk_sys = ~clk_sys;
	initial begin
		#200000;
		failures++;
		close_out;
	end
	initial begin
		void'($urandom(76458));
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		@(posedge clk_sys);
		rd(A_RXH, 4'h0);
		rd(A_MODE, 4'h0);
		rd(A_FMT, 4'h0);
		rd(A_BAUD, 4'hC);
		wr(A_RXL, 4'hF);
		wr(A_STAT, 4'hF);
		rd(A_RXL, 4'h0);
		rd(A_STAT, 4'h0);
		wr(12'h298, 4'h5);
		chk({31'h0, err}, 32'h1);
		$display("test reset done");
		for (int i = 0; i < 4; i++) begin
			v = $urandom;
			wr(A_FMT, v[3:0]);
			rd(A_FMT, v[3:0]);
			wr(A_MODE, v[3:0] & 4'h7);
			rd(A_MODE, v[3:0] & 4'h7);
			wr(A_BAUD, v[7:4]);
			rd(A_BAUD, v[7:4]);
		end
		wr(A_BAUD, 4'hC);
		wr(A_MODE, 4'hE);
		$display("test fields done");
		frame(4'h0, 1'b0, 1'b1, 4'h0);
		frame(4'h2, 1'b0, 1'b1, 4'h0);
		frame(4'h6, 1'b1, 1'b1, 4'h4);
		frame(4'hE, 1'b0, 1'b1, 4'h0);
		frame(4'h0, 1'b0, 1'b0, 4'h1);
		rd(A_STAT, 4'h0);
		rd(A_MODE, 4'hE);
		$display("test uart done");
		a = $urandom;
		b = $urandom;
		for (int i = 0; i < 2; i++)
			fork
				i_serial_line_model.uart(i ? b : a, 1'b0, 1'b0, 1'b1);
				wait_irq;
			join
		rd(A_STAT, 4'h2);
		rd(A_RXL, a[3:0]);
		rd(A_RXH, a[7:4]);
		$display("test overrun done");
		wr(A_MODE, 4'hF);
		fork
			i_serial_line_model.sync(b);
			wait_irq;
		join
		rd(A_MODE, 4'h7);
		rd(A_RXL, b[3:0]);
		rd(A_RXH, b[7:4]);
		$display("test sync done");
		rd(A_STAT, 4'h0);
		c = $urandom;
		fork
			begin
				get_tx(r0);
				get_tx(r1);
			end
			begin
				wr(A_TXL, a[3:0]);
				wr(A_TXH, a[7:4]);
				wr(A_TXL, b[3:0]);
				wr(A_TXH, b[7:4]);
				rd(A_STAT, 4'h8);
				wr(A_TXL, c[3:0]);
				wr(A_TXH, c[7:4]);
			end
		join
		chk({24'h0, r0}, {24'h0, a});
		chk({24'h0, r1}, {24'h0, c});
		rd(A_STAT, 4'h0);
		$display("test send done");
		close_out;
	end
endmodule
bind serial_port_core serial_port_core_properties #(.BAUD_CYCLES(BAUD_CYCLES))
	i_serial_port_core_properties (
	.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
	.prdata_o(prdata_o), .pslverr_o(pslverr_o), .rxd_i(rxd_i), .rx_clk_i(rx_clk_i),
	.rx_clk_o(rx_clk_o), .rx_clk_oe_o(rx_clk_oe_o), .txd_o(txd_o), .rx_irq_o(rx_irq_o));
`default_nettype wire
